// file: hdl/wdc_defines.svh
`ifndef WDC_DEFINES_SVH
`define WDC_DEFINES_SVH

// ----------------------------------------------------------------
// watchdog_control field positions
// ----------------------------------------------------------------
`define WDC_BIT_UNLOCK 0
`define WDC_BIT_ENABLE 1
`define WDC_BIT_STATUS 2
`define WDC_BIT_RSEL 3
`define WDC_PRE_LSB 4
`define WDC_PRE_MSB 7

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define WDC_RST_VAL 8'h00
`define WDC_RSEL_RST 1'b0
`define WDC_PRE_RST 4'h0
`define WDC_PRE_IMMEDIATE 4'h8

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define WDC_TICK_CYCLES 1024
`define WDC_CNT_W 32

`endif

// file: hdl/wdc_pkg.sv
`default_nettype none

package wdc_pkg;

  // ----------------------------------------------------------------
  // unlock sequence states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    WDC_LOCKED = 3'b001,  // writes ignored except the unlock
    WDC_ARMING = 3'b010,  // unlock seen, its instruction still running
    WDC_OPEN = 3'b100     // next instruction may write the register
  } wdc_unlock_t;

  // prescaler select field
  typedef logic [3:0] wdc_pre_t;

  // timeout limit in cycles for a prescaler code, zero for no count
  function automatic logic [31:0] wdc_limit(input logic [3:0] pre, input logic [31:0] base);
    logic [31:0] lim;
    lim = 32'h0;
    if (pre < 4'h8) begin
      lim = base << pre;
    end
    return lim;
  endfunction

endpackage

`default_nettype wire

// file: hdl/wdc_timer_if.sv
`default_nettype none

// ----------------------------------------------------------------
// control link between register logic and timeout counter
// ----------------------------------------------------------------
interface wdc_timer_if;
  logic run;                  // counter enabled
  logic restart;              // one-cycle pulse, clears the counter
  wdc_pkg::wdc_pre_t pre;     // period select
  logic timeout;              // one-cycle pulse at expiry

  modport ctrl (output run, output restart, output pre, input timeout);
  modport timer (input run, input restart, input pre, output timeout);
endinterface

`default_nettype wire

// file: hdl/wdc_timer.sv
`include "wdc_defines.svh"
`default_nettype none

// ----------------------------------------------------------------
// timeout counter
// ----------------------------------------------------------------
module wdc_timer #(
  parameter int unsigned TICK_CYCLES = `WDC_TICK_CYCLES
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // control link
  wdc_timer_if.timer tif
);

  logic [`WDC_CNT_W-1:0] cnt_ff;  // cycles since restart
  logic timeout_ff;               // expiry pulse
  logic [31:0] limit;             // period of current selection
  logic expire;                   // count reached the period

  // period from the prescaler code
  always_comb begin
    limit = wdc_pkg::wdc_limit(tif.pre, 32'(TICK_CYCLES));
  end

  // immediate code expires at once, reserved codes never
  always_comb begin
    if (tif.pre == `WDC_PRE_IMMEDIATE) begin
      expire = 1'b1;
    end else if (limit == 32'h0) begin
      expire = 1'b0;
    end else begin
      expire = (cnt_ff == (limit - 32'h1));
    end
  end

  // counter, cleared by restart, wraps at expiry
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cnt_ff <= '0;
    end else if (i_clk_en) begin
      if (tif.restart || !tif.run || expire) begin
        cnt_ff <= '0;
      end else begin
        cnt_ff <= cnt_ff + 32'h1;
      end
    end
  end

  // expiry pulse, suppressed by a restart in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      timeout_ff <= 1'b0;
    end else if (i_clk_en) begin
      timeout_ff <= tif.run && !tif.restart && expire && !timeout_ff;
    end
  end

  assign tif.timeout = timeout_ff;

endmodule

`default_nettype wire

// file: hdl/wdc_top.sv
`include "wdc_defines.svh"
`default_nettype none

// What this block does
// - timeout sets the status flag
// - flag clears by write 0 or hard reset
// - writing enable 1 enables and restarts counters
// - unrenewed timeout raises reset or interrupt
// - enable clears on write0, reset response, supply
// - writes land only right after unlock

// ----------------------------------------------------------------
// watchdog control and status register
// ----------------------------------------------------------------
module wdc_top #(
  parameter int unsigned TICK_CYCLES = `WDC_TICK_CYCLES
) (
  // clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // register port from the core
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_bit_wr,
  input wire logic [2:0] i_bit_idx,
  input wire logic i_bit_val,
  input wire logic i_instr_end,
  output logic [7:0] o_reg_rdata,
  // system events
  input wire logic i_supply_monitor_irq,
  // watchdog responses
  output logic o_wdt_reset,
  output logic o_wdt_irq,
  output logic o_wdt_running
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  wdc_pkg::wdc_unlock_t unlock_ff;      // unlock sequence state
  wdc_pkg::wdc_unlock_t nxt_unlock;     // next unlock state
  logic status_ff;                      // timeout_status_flag
  logic enable_ff;                      // watchdog_enable_restart
  logic rsel_ff;                        // response_select
  wdc_pkg::wdc_pre_t pre_ff;            // prescaler field
  logic reset_ff;                       // reset request pulse
  logic irq_ff;                         // interrupt request pulse
  logic restart_ff;                     // counter restart pulse

  // ----------------------------------------------------------------
  // write merging
  // ----------------------------------------------------------------
  logic any_wr;            // byte or bit write this cycle
  logic [7:0] cur_val;     // present register image
  logic [7:0] wr_val;      // image after the write
  logic unlock_req;        // write that sets the unlock bit
  logic wr_ok;             // write that may change the register
  logic timeout;           // counter expiry

  wdc_timer_if tif ();

  // current image, unlock bit shows the arming or open state
  always_comb begin
    cur_val = {pre_ff, rsel_ff, status_ff, enable_ff, (unlock_ff != wdc_pkg::WDC_LOCKED)};
  end

  // merge a byte or single-bit write into the image
  always_comb begin
    wr_val = cur_val;
    if (i_reg_wr) begin
      wr_val = i_reg_wdata;
    end else if (i_bit_wr) begin
      wr_val[i_bit_idx] = i_bit_val;
    end
  end

  assign any_wr = i_reg_wr || i_bit_wr;
  assign unlock_req = any_wr && wr_val[`WDC_BIT_UNLOCK] && (unlock_ff == wdc_pkg::WDC_LOCKED);
  assign wr_ok = any_wr && (unlock_ff == wdc_pkg::WDC_OPEN);
  assign timeout = tif.timeout;

  // ----------------------------------------------------------------
  // unlock sequence
  // ----------------------------------------------------------------

  // next state of the unlock sequence
  always_comb begin
    nxt_unlock = unlock_ff;
    case (unlock_ff)
      wdc_pkg::WDC_LOCKED: begin
        // unlock write arms; ends now if its instruction ends now
        if (unlock_req && i_instr_end) begin
          nxt_unlock = wdc_pkg::WDC_OPEN;
        end else if (unlock_req) begin
          nxt_unlock = wdc_pkg::WDC_ARMING;
        end
      end
      wdc_pkg::WDC_ARMING: begin
        // wait for the unlocking instruction to finish
        if (i_instr_end) begin
          nxt_unlock = wdc_pkg::WDC_OPEN;
        end
      end
      wdc_pkg::WDC_OPEN: begin
        // one instruction only, written or not
        if (i_instr_end || wr_ok) begin
          nxt_unlock = wdc_pkg::WDC_LOCKED;
        end
      end
      default: begin
        nxt_unlock = wdc_pkg::WDC_LOCKED;
      end
    endcase
  end

  // unlock state register
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      unlock_ff <= wdc_pkg::WDC_LOCKED;
    end else if (i_clk_en) begin
      unlock_ff <= nxt_unlock;
    end
  end

  // ----------------------------------------------------------------
  // register fields
  // ----------------------------------------------------------------

  // prescaler and response select, writable only when open
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pre_ff <= `WDC_PRE_RST;
      rsel_ff <= `WDC_RSEL_RST;
    end else if (i_clk_en && wr_ok) begin
      pre_ff <= wr_val[`WDC_PRE_MSB:`WDC_PRE_LSB];
      rsel_ff <= wr_val[`WDC_BIT_RSEL];
    end
  end

  // status flag: timeout sets, write 0 clears, set wins
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      status_ff <= 1'b0;
    end else if (i_clk_en) begin
      if (timeout) begin
        status_ff <= 1'b1;
      end else if (wr_ok && !wr_val[`WDC_BIT_STATUS]) begin
        status_ff <= 1'b0;
      end
    end
  end

  // enable bit and its clear conditions
  // a reset response wins over a same-cycle enable write
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      enable_ff <= 1'b0;
    end else if (i_clk_en) begin
      if (i_supply_monitor_irq) begin
        enable_ff <= 1'b0;
      end else if (timeout && !rsel_ff) begin
        enable_ff <= 1'b0;
      end else if (wr_ok) begin
        enable_ff <= wr_val[`WDC_BIT_ENABLE];
      end
    end
  end

  // restart pulse whenever an accepted write sets enable
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      restart_ff <= 1'b0;
    end else if (i_clk_en) begin
      restart_ff <= wr_ok && wr_val[`WDC_BIT_ENABLE];
    end
  end

  // ----------------------------------------------------------------
  // responses
  // ----------------------------------------------------------------

  // reset or interrupt on expiry, picked by response select
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      reset_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else if (i_clk_en) begin
      reset_ff <= timeout && !rsel_ff;
      irq_ff <= timeout && rsel_ff;
    end
  end

  // ----------------------------------------------------------------
  // counter hookup
  // ----------------------------------------------------------------
  assign tif.run = enable_ff;
  assign tif.restart = restart_ff;
  assign tif.pre = pre_ff;

  wdc_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .tif(tif.timer)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_reg_rdata = cur_val;
  assign o_wdt_reset = reset_ff;
  assign o_wdt_irq = irq_ff;
  assign o_wdt_running = enable_ff;

endmodule

`default_nettype wire

// file: testbench/wdc_top_properties.sv
`include "wdc_defines.svh"
`default_nettype none

// ----------------------------------------------------------------
// port-level checks of the watchdog control register
// ----------------------------------------------------------------
module wdc_top_properties #(
  parameter int unsigned TICK_CYCLES = `WDC_TICK_CYCLES
) (
  // clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // register port
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_bit_wr,
  input wire logic [2:0] i_bit_idx,
  input wire logic i_bit_val,
  input wire logic i_instr_end,
  input wire logic [7:0] o_reg_rdata,
  // events and responses
  input wire logic i_supply_monitor_irq,
  input wire logic o_wdt_reset,
  input wire logic o_wdt_irq,
  input wire logic o_wdt_running
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  // image is clear when reset lets go
  property p_rst_img;
    $rose(i_rst_n) |-> o_reg_rdata == 8'h00 && !o_wdt_running;
  endproperty
  a_rst_img: assert property (p_rst_img) else $error("image not clear after reset");
  // any response shows the status flag
  property p_to_status;
    (o_wdt_reset || o_wdt_irq) |-> o_reg_rdata[2];
  endproperty
  a_to_status: assert property (p_to_status) else $error("status flag missing");
  // status only drops on a write
  property p_status_hold;
    o_reg_rdata[2] && !i_reg_wr && !i_bit_wr |=> o_reg_rdata[2];
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status flag lost");
  // interrupt only with response select high
  property p_irq_sel;
    o_wdt_irq |-> $past(o_reg_rdata[3]) && !o_wdt_reset;
  endproperty
  a_irq_sel: assert property (p_irq_sel) else $error("interrupt with wrong select");
  // reset response drops the enable
  property p_rst_sel;
    o_wdt_reset |-> !$past(o_reg_rdata[3]) && !o_wdt_running;
  endproperty
  a_rst_sel: assert property (p_rst_sel) else $error("reset response wrong");
  // supply monitor stops the watchdog
  property p_supply;
    i_supply_monitor_irq && i_clk_en |=> !o_wdt_running;
  endproperty
  a_supply: assert property (p_supply) else $error("enable kept on supply event");
  // locked writes change nothing
  property p_locked;
    !o_reg_rdata[0] && !o_wdt_running && (i_reg_wr || i_bit_wr)
      |=> o_reg_rdata[7:1] == $past(o_reg_rdata[7:1]);
  endproperty
  a_locked: assert property (p_locked) else $error("locked write took effect");
  // unlock lapses after one idle instruction
  property p_unlock_once;
    $rose(o_reg_rdata[0]) && i_clk_en && i_instr_end && !i_reg_wr && !i_bit_wr
      ##1 i_clk_en && i_instr_end && !i_bit_wr && !i_reg_wdata[0] |=> !o_reg_rdata[0];
  endproperty
  a_unlock_once: assert property (p_unlock_once) else $error("unlock outlived its slot");
endmodule

bind wdc_top wdc_top_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
  .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_bit_wr(i_bit_wr),
  .i_bit_idx(i_bit_idx), .i_bit_val(i_bit_val), .i_instr_end(i_instr_end),
  .o_reg_rdata(o_reg_rdata), .i_supply_monitor_irq(i_supply_monitor_irq),
  .o_wdt_reset(o_wdt_reset), .o_wdt_irq(o_wdt_irq), .o_wdt_running(o_wdt_running));

`default_nettype wire

// file: testbench/wdc_top_tb.sv
`default_nettype none

// ----------------------------------------------------------------
// bench for the watchdog control register
// ----------------------------------------------------------------
module wdc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned TICKS = 4; // short base period
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic bit_wr = 1'b0;
  logic [2:0] bit_idx = 3'h0;
  logic bit_val = 1'b0;
  logic supply_irq = 1'b0;
  logic instr_end = 1'b1; // last cycle of an instruction
  logic clk_en = 1'b1; // low freezes the block
  logic [7:0] reg_rdata;
  logic wdt_reset, wdt_irq, wdt_running;
  int err_count = 0;
  int checked = 0;
  int resp_cnt = 0; // responses seen so far
  logic last_irq = 1'b0; // kind of the latest response

  wdc_top #(.TICK_CYCLES(TICKS)) dut (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_reg_wr(reg_wr),
    .i_reg_wdata(reg_wdata), .i_bit_wr(bit_wr), .i_bit_idx(bit_idx), .i_bit_val(bit_val),
    .i_instr_end(instr_end), .o_reg_rdata(reg_rdata), .i_supply_monitor_irq(supply_irq),
    .o_wdt_reset(wdt_reset), .o_wdt_irq(wdt_irq), .o_wdt_running(wdt_running));

  always #10 sys_clk = ~sys_clk;

  // count one-cycle responses so no pulse is missed
  always @(posedge sys_clk) begin
    if (wdt_reset || wdt_irq) begin
      resp_cnt <= resp_cnt + 1;
      last_irq <= wdt_irq;
    end
  end

  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one single-cycle instruction, driven from a falling edge
  task automatic op(input logic rw, input logic [7:0] d, input logic bw,
                    input logic [2:0] ix, input logic bv);
    reg_wr = rw;
    reg_wdata = d;
    bit_wr = bw;
    bit_idx = ix;
    bit_val = bv;
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // unlock, write, then one idle instruction
  task automatic prot(input logic [7:0] d);
    op(1'b0, 8'h00, 1'b1, 3'h0, 1'b1);
    op(1'b1, d, 1'b0, 3'h0, 1'b0);
    op(1'b0, 8'h00, 1'b0, 3'h0, 1'b0);
  endtask

  task automatic t_locked;
    op(1'b1, 8'h0a, 1'b0, 3'h0, 1'b0);
    op(1'b0, 8'h00, 1'b1, 3'h1, 1'b1);
    op(1'b0, 8'h00, 1'b0, 3'h0, 1'b0);
    chk(reg_rdata, 8'h00);
    op(1'b0, 8'h00, 1'b1, 3'h0, 1'b1);
    op(1'b0, 8'h00, 1'b0, 3'h0, 1'b0);
    op(1'b1, 8'h02, 1'b0, 3'h0, 1'b0);
    op(1'b0, 8'h00, 1'b0, 3'h0, 1'b0);
    chk(reg_rdata, 8'h00);
    $display("test locked done");
  endtask

  // enable with a setting, wait for the response and judge it
  task automatic t_resp(input logic [7:0] d, input logic irq, input int lo, input int hi);
    int snap;
    int n;
    snap = resp_cnt;
    prot(d);
    if (lo > 0) chk(reg_rdata, d);
    n = 0;
    while (resp_cnt == snap && n <= hi) begin
      op(1'b0, 8'h00, 1'b0, 3'h0, 1'b0);
      n++;
    end
    if (n > hi) begin
      err_count++;
      test_done;
    end
    chk(8'(n >= lo), 8'h01);
    chk(8'(last_irq), 8'(irq));
    chk(reg_rdata, (d | 8'h04) & (irq ? 8'hff : 8'hfd));
    repeat (3) op(1'b0, 8'h00, 1'b0, 3'h0, 1'b0);
    chk(reg_rdata & 8'h04, 8'h04);
    $display("test response %h done", d);
  endtask

  task automatic t_restart;
    int snap;
    prot(8'h0a);
    prot(8'h0a);
    snap = resp_cnt;
    repeat (5) prot(8'h0a);
    chk(8'(resp_cnt - snap), 8'h00);
    repeat (12) op(1'b0, 8'h00, 1'b0, 3'h0, 1'b0);
    chk(8'(resp_cnt > snap), 8'h01);
    $display("test restart done");
  endtask

  task automatic t_stop;
    supply_irq = 1'b1;
    op(1'b0, 8'h00, 1'b0, 3'h0, 1'b0);
    supply_irq = 1'b0;
    chk(8'(wdt_running), 8'h00);
    prot(8'h0a);
    chk(8'(wdt_running), 8'h01);
    prot(8'h08);
    chk(reg_rdata, 8'h08);
    $display("test stop done");
  endtask

  // reserved period code, then an unlock that spans long instructions
  task automatic t_arming;
    int snap;
    prot(8'h92);
    chk(reg_rdata, 8'h92);
    snap = resp_cnt;
    repeat (20) op(1'b0, 8'h00, 1'b0, 3'h0, 1'b0);
    chk(8'(resp_cnt - snap), 8'h00);
    instr_end = 1'b0;
    op(1'b0, 8'h00, 1'b1, 3'h0, 1'b1);
    op(1'b1, 8'h00, 1'b0, 3'h0, 1'b0);
    chk(reg_rdata, 8'h93);
    instr_end = 1'b1;
    op(1'b0, 8'h00, 1'b0, 3'h0, 1'b0);
    instr_end = 1'b0;
    op(1'b0, 8'h00, 1'b0, 3'h0, 1'b0);
    chk(reg_rdata, 8'h93);
    instr_end = 1'b1;
    op(1'b0, 8'h00, 1'b1, 3'h1, 1'b0);
    chk(reg_rdata, 8'h90);
    chk(8'(wdt_running), 8'h00);
    $display("test arming done");
  endtask

  // frozen enable, supply event against a write, hard reset, set wins
  task automatic t_hard;
    int snap;
    prot(8'h02);
    snap = resp_cnt;
    clk_en = 1'b0;
    repeat (10) op(1'b0, 8'h00, 1'b0, 3'h0, 1'b0);
    clk_en = 1'b1;
    chk(8'(resp_cnt - snap), 8'h00);
    chk(reg_rdata, 8'h02);
    op(1'b0, 8'h00, 1'b1, 3'h0, 1'b1);
    supply_irq = 1'b1;
    op(1'b1, 8'h02, 1'b0, 3'h0, 1'b0);
    supply_irq = 1'b0;
    chk(8'(wdt_running), 8'h00);
    prot(8'h0a);
    repeat (8) op(1'b0, 8'h00, 1'b0, 3'h0, 1'b0);
    chk(reg_rdata, 8'h0e);
    rst_n = 1'b0;
    repeat (2) op(1'b0, 8'h00, 1'b0, 3'h0, 1'b0);
    rst_n = 1'b1;
    chk(reg_rdata, 8'h00);
    prot(8'h0a);
    repeat (3) op(1'b0, 8'h00, 1'b0, 3'h0, 1'b0);
    op(1'b0, 8'h00, 1'b1, 3'h0, 1'b1);
    op(1'b1, 8'h0a, 1'b0, 3'h0, 1'b0);
    chk(reg_rdata, 8'h0e);
    $display("test hard reset done");
  endtask

  initial begin
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    chk(reg_rdata, 8'h00);
    t_locked;
    t_resp(8'h02, 1'b0, TICKS - 2, TICKS + 6);
    t_resp(8'h0a, 1'b1, TICKS - 2, TICKS + 6);
    t_restart;
    t_stop;
    t_resp(8'h82, 1'b0, 0, 4);
    t_arming;
    t_hard;
    test_done;
  end
endmodule

`default_nettype wire
